// File: logic/timer_map.vh
// What this block does
// - 8-bit up-counter counts while count enable set
// - Prescaler divides master clock by two-power
// - Divider preload copied only at update event
// - Divider register reads return preload value
// - Reload preload bit selects direct or buffered
// - One-pulse clears count enable at update
// - Update source bit limits requests to overflow
// - Update block holds shadows; forced reinit stays
// - Master select picks trigger output source
// - Exported enable ORs enable bit, gated trigger
// - Sync delay postpones trigger input effect
// - Trigger select picks internal trigger two/three
// - Slave mode 000 counts on internal clock
// - Slave mode 100 edge reinitialises and updates
// - Slave mode 101 counts while trigger high
// - Slave mode 110 edge starts counter only
// - Slave mode 111 trigger edges clock counter
// - Trigger flag on active edge, write-0 clear
// - Update flag on overflow, software update or slave mode 100 reset edge
// - Trigger generate sets trigger flag, self-clears
// - Update generate reinitialises, updates, self-clears
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH

// =========================================
// Register indexes, byte address is index*4
`define IDX_CONTROL_ONE   4'h0
`define IDX_MASTER_MODE   4'h1
`define IDX_SLAVE_MODE    4'h2
`define IDX_IRQ_ENABLE    4'h3
`define IDX_EVENT_STATUS  4'h4
`define IDX_EVENT_GEN     4'h5
`define IDX_COUNT_VALUE   4'h6
`define IDX_CLOCK_DIVIDER 4'h7
`define IDX_RELOAD_VALUE  4'h8

// =========================================
// Field positions
`define BIT_COUNT_ENABLE  0
`define BIT_UPDATE_BLOCK  1
`define BIT_UPDATE_SOURCE 2
`define BIT_ONE_PULSE     3
`define BIT_RELOAD_PRE    7
`define BIT_SYNC_DELAY    7
`define BIT_UPDATE_FLAG   0
`define BIT_TRIGGER_FLAG  6

// =========================================
// Reset values
`define RST_BYTE          8'h00
`define RST_RELOAD        8'hFF

// =========================================
// Mode codes
`define MMS_RESET         3'h0
`define MMS_ENABLE        3'h1
`define MMS_UPDATE        3'h2
`define TS_ITR_TWO        3'h2
`define TS_ITR_THREE      3'h3
`define SMS_OFF           3'h0
`define SMS_RESET         3'h4
`define SMS_GATED         3'h5
`define SMS_TRIGGER       3'h6
`define SMS_EXT_CLOCK     3'h7

`endif

// File: logic/basic_timer.v
`timescale 1ns/1ps
`include "timer_map.vh"

module basic_timer #(
  parameter ADDR_W = 12
)(
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire              internal_trigger_two,
  input  wire              internal_trigger_three,
  output reg               trigger_out,
  output reg               timer_irq
);

  // =========================================
  // Helpers
  function index_ok;
    input [ADDR_W-1:0] a;
    begin
      index_ok = (a[ADDR_W-1:6] == {(ADDR_W-6){1'b0}}) &&
                 (a[1:0] == 2'h0) &&
                 (a[5:2] <= `IDX_RELOAD_VALUE);
    end
  endfunction

  function [6:0] divider_mask;
    input [2:0] sel;
    begin
      divider_mask = 7'h7F >> (3'h7 - sel);
      if (sel == 3'h0)
        divider_mask = 7'h00;
    end
  endfunction

  // =========================================
  // State
  reg        count_enable_reg;
  reg        update_block_reg;
  reg        update_source_sel_reg;
  reg        one_pulse_reg;
  reg        reload_preload_en_reg;
  reg  [2:0] master_out_select_reg;
  reg        sync_delay_reg;
  reg  [2:0] trigger_select_reg;
  reg  [2:0] slave_mode_select_reg;
  reg        update_irq_en_reg;
  reg        trigger_irq_en_reg;
  reg        update_flag_reg;
  reg        trigger_flag_reg;
  reg  [7:0] count_value_reg;
  reg  [2:0] divider_preload_reg;
  reg  [2:0] divider_active_reg;
  reg  [6:0] divider_count_reg;
  reg  [7:0] reload_preload_reg;
  reg  [7:0] reload_active_reg;
  reg        trig_dly_reg;
  reg        trig_prev_reg;

  // =========================================
  // Bus decode
  wire [3:0] idx     = paddr[5:2];
  wire       setup   = psel & ~penable;
  wire       access  = psel & penable & pready;
  wire       wr      = access & pwrite & ~pslverr;
  wire [7:0] wbyte   = pwdata[7:0];
  wire       wr_cr1  = wr & (idx == `IDX_CONTROL_ONE);
  wire       wr_cr2  = wr & (idx == `IDX_MASTER_MODE);
  wire       wr_smcr = wr & (idx == `IDX_SLAVE_MODE);
  wire       wr_ier  = wr & (idx == `IDX_IRQ_ENABLE);
  wire       wr_sr   = wr & (idx == `IDX_EVENT_STATUS);
  wire       wr_egr  = wr & (idx == `IDX_EVENT_GEN);
  wire       wr_cnt  = wr & (idx == `IDX_COUNT_VALUE);
  wire       wr_psc  = wr & (idx == `IDX_CLOCK_DIVIDER);
  wire       wr_arr  = wr & (idx == `IDX_RELOAD_VALUE);

  // Generate bits exist only as one-cycle pulses
  wire update_generate  = wr_egr & wbyte[`BIT_UPDATE_FLAG];
  wire trigger_generate = wr_egr & wbyte[`BIT_TRIGGER_FLAG];

  // =========================================
  // Trigger selection and edge detection
  reg trig_raw;
  always @*
  begin
    case (trigger_select_reg)
      `TS_ITR_TWO:   trig_raw = internal_trigger_two;
      `TS_ITR_THREE: trig_raw = internal_trigger_three;
      default:       trig_raw = 1'b0;
    endcase
  end

  // One extra stage keeps chained timers aligned with our output
  wire trig_use  = sync_delay_reg ? trig_dly_reg : trig_raw;
  wire trig_rise = trig_use & ~trig_prev_reg;
  wire trig_fall = ~trig_use & trig_prev_reg;

  // Select changes while a mode is live can fake an edge
  wire mode_reset = (slave_mode_select_reg == `SMS_RESET);
  wire mode_gated = (slave_mode_select_reg == `SMS_GATED);
  wire mode_trig  = (slave_mode_select_reg == `SMS_TRIGGER);
  wire mode_ext   = (slave_mode_select_reg == `SMS_EXT_CLOCK);
  wire mode_off   = (slave_mode_select_reg == `SMS_OFF);

  wire trig_reset = mode_reset & trig_rise;
  wire trig_start = mode_trig & trig_rise;
  wire trig_event = (mode_gated & (trig_rise | trig_fall)) |
                    ((mode_reset | mode_trig | mode_ext) &
                     trig_rise);

  // =========================================
  // Prescaler and counter
  wire [6:0] mask = divider_mask(divider_active_reg);

  reg divider_input_clock;
  always @*
  begin
    divider_input_clock = 1'b0;
    if (count_enable_reg)
    begin
      if (mode_ext)
        divider_input_clock = trig_rise;
      else if (mode_gated)
        divider_input_clock = trig_use;
      else
        divider_input_clock = 1'b1;
    end
  end

  wire divider_full  = (divider_count_reg & mask) == mask;
  wire counter_clock = divider_input_clock & divider_full;
  wire at_reload     = (count_value_reg == reload_active_reg);
  wire overflow      = counter_clock & at_reload;
  wire reinit        = update_generate | trig_reset;

  // Forced updates count as software requests
  wire update_event  = ~update_block_reg &
                       (overflow | reinit);
  wire update_req    = update_event &
                       (overflow | ~update_source_sel_reg);

  wire enable_signal = count_enable_reg |
                       (mode_gated & trig_use);

  // =========================================
  // Counter datapath
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_value_reg   <= `RST_BYTE;
      divider_count_reg <= 7'h00;
    end
    else
    begin
      if (wr_cnt)
        count_value_reg <= wbyte;
      else if (reinit)
        count_value_reg <= `RST_BYTE;
      else if (overflow)
        count_value_reg <= `RST_BYTE;
      else if (counter_clock)
        count_value_reg <= count_value_reg + 8'h01;
      if (reinit)
        divider_count_reg <= 7'h00;
      else if (counter_clock)
        divider_count_reg <= 7'h00;
      else if (divider_input_clock)
        divider_count_reg <= divider_count_reg + 7'h01;
    end
  end

  // =========================================
  // Shadow registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      divider_preload_reg <= 3'h0;
      divider_active_reg  <= 3'h0;
      reload_preload_reg  <= `RST_RELOAD;
      reload_active_reg   <= `RST_RELOAD;
    end
    else
    begin
      if (wr_psc)
        divider_preload_reg <= wbyte[2:0];
      if (wr_arr)
        reload_preload_reg <= wbyte;
      if (update_event)
        divider_active_reg <= divider_preload_reg;
      if (wr_arr && !reload_preload_en_reg)
        reload_active_reg <= wbyte;
      else if (update_event && reload_preload_en_reg)
        reload_active_reg <= reload_preload_reg;
    end
  end

  // =========================================
  // Control registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_enable_reg      <= 1'b0;
      update_block_reg      <= 1'b0;
      update_source_sel_reg <= 1'b0;
      one_pulse_reg         <= 1'b0;
      reload_preload_en_reg <= 1'b0;
      master_out_select_reg <= 3'h0;
      sync_delay_reg        <= 1'b0;
      trigger_select_reg    <= 3'h0;
      slave_mode_select_reg <= 3'h0;
      update_irq_en_reg     <= 1'b0;
      trigger_irq_en_reg    <= 1'b0;
    end
    else
    begin
      if (wr_cr1)
      begin
        update_block_reg      <= wbyte[`BIT_UPDATE_BLOCK];
        update_source_sel_reg <= wbyte[`BIT_UPDATE_SOURCE];
        one_pulse_reg         <= wbyte[`BIT_ONE_PULSE];
        reload_preload_en_reg <= wbyte[`BIT_RELOAD_PRE];
      end
      // Hardware start and stop override a same-cycle write
      if (trig_start)
        count_enable_reg <= 1'b1;
      else if (update_event && one_pulse_reg)
        count_enable_reg <= 1'b0;
      else if (wr_cr1)
        count_enable_reg <= wbyte[`BIT_COUNT_ENABLE];
      if (wr_cr2)
        master_out_select_reg <= wbyte[6:4];
      if (wr_smcr)
      begin
        sync_delay_reg        <= wbyte[`BIT_SYNC_DELAY];
        trigger_select_reg    <= wbyte[6:4];
        slave_mode_select_reg <= wbyte[2:0];
      end
      if (wr_ier)
      begin
        update_irq_en_reg  <= wbyte[`BIT_UPDATE_FLAG];
        trigger_irq_en_reg <= wbyte[`BIT_TRIGGER_FLAG];
      end
    end
  end

  // =========================================
  // Flags, set wins over a same-cycle clear
  wire clr_uf = wr_sr & ~wbyte[`BIT_UPDATE_FLAG];
  wire clr_tf = wr_sr & ~wbyte[`BIT_TRIGGER_FLAG];
  wire set_tf = trig_event | trigger_generate;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      update_flag_reg  <= 1'b0;
      trigger_flag_reg <= 1'b0;
      trig_dly_reg     <= 1'b0;
      trig_prev_reg    <= 1'b0;
    end
    else
    begin
      update_flag_reg  <= (update_flag_reg & ~clr_uf) |
                          update_req;
      trigger_flag_reg <= (trigger_flag_reg & ~clr_tf) |
                          set_tf;
      trig_dly_reg     <= trig_raw;
      trig_prev_reg    <= trig_use;
    end
  end

  // =========================================
  // Trigger output and interrupt
  reg trig_out_next;
  always @*
  begin
    case (master_out_select_reg)
      `MMS_RESET:  trig_out_next = update_generate;
      `MMS_ENABLE: trig_out_next = enable_signal;
      `MMS_UPDATE: trig_out_next = update_event;
      default:     trig_out_next = 1'b0;
    endcase
  end

  wire irq_next =
    ((update_flag_reg & ~clr_uf) | update_req) & update_irq_en_reg |
    ((trigger_flag_reg & ~clr_tf) | set_tf) & trigger_irq_en_reg;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trigger_out <= 1'b0;
      timer_irq   <= 1'b0;
    end
    else
    begin
      trigger_out <= trig_out_next;
      timer_irq   <= irq_next;
    end
  end

  // =========================================
  // Read mux, reserved bits zero
  reg [7:0] rbyte;
  always @*
  begin
    rbyte = 8'h00;
    case (idx)
      `IDX_CONTROL_ONE:   rbyte = {reload_preload_en_reg, 3'h0,
                                   one_pulse_reg,
                                   update_source_sel_reg,
                                   update_block_reg,
                                   count_enable_reg};
      `IDX_MASTER_MODE:   rbyte = {1'b0, master_out_select_reg, 4'h0};
      `IDX_SLAVE_MODE:    rbyte = {sync_delay_reg, trigger_select_reg,
                                   1'b0, slave_mode_select_reg};
      `IDX_IRQ_ENABLE:    rbyte = {1'b0, trigger_irq_en_reg, 5'h00,
                                   update_irq_en_reg};
      `IDX_EVENT_STATUS:  rbyte = {1'b0, trigger_flag_reg, 5'h00,
                                   update_flag_reg};
      `IDX_COUNT_VALUE:   rbyte = count_value_reg;
      `IDX_CLOCK_DIVIDER: rbyte = {5'h00, divider_preload_reg};
      `IDX_RELOAD_VALUE:  rbyte = reload_preload_reg;
      default:            rbyte = 8'h00;
    endcase
  end

  // =========================================
  // APB slave, one wait-free access phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready <= setup;
      if (setup)
      begin
        pslverr <= ~index_ok(paddr);
        if (!pwrite && index_ok(paddr))
          prdata <= {24'h000000, rbyte};
        else
          prdata <= 32'h00000000;
      end
      else
      begin
        pslverr <= 1'b0;
        prdata  <= 32'h00000000;
      end
    end
  end

endmodule

// File: bench/timer_sva.sv
`timescale 1ns/1ps
// ======================================
// Bus and interrupt checks at the ports
module timer_sva #(
  parameter ADDR_W = 12
)(
  input logic              pclk,
  input logic              presetn,
  input logic              psel,
  input logic              penable,
  input logic              pwrite,
  input logic [ADDR_W-1:0] paddr,
  input logic [31:0]       pwdata,
  input logic [31:0]       prdata,
  input logic              pready,
  input logic              pslverr,
  input logic              internal_trigger_two,
  input logic              internal_trigger_three,
  input logic              trigger_out,
  input logic              timer_irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_ready_setup:
    assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_single:
    assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_ready:
    assert property (pslverr |-> pready)
    else $error("error without ready");
  a_write_rdata:
    assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on write");
  a_upper_zero:
    assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data set");
  a_bad_addr:
    assert property (psel && !penable && paddr[1:0] != 2'h0
      |=> pslverr && prdata == 32'h0)
    else $error("unaligned address accepted");
  a_good_addr:
    assert property (psel && !penable && paddr[1:0] == 2'h0 &&
      paddr < 12'h024 |=> !pslverr)
    else $error("mapped address refused");
  a_irq_off:
    assert property (pready && pwrite && !pslverr && paddr == 12'h00C
      && pwdata[7:0] == 8'h00 |-> ##2 !timer_irq)
    else $error("interrupt with sources masked");
endmodule

bind basic_timer timer_sva #(.ADDR_W(ADDR_W)) i_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .internal_trigger_two(internal_trigger_two),
  .internal_trigger_three(internal_trigger_three),
  .trigger_out(trigger_out), .timer_irq(timer_irq)
);

// File: bench/trigger_source.sv
`timescale 1ns/1ps
// ======================================
// Neighbouring timers' trigger outputs
module trigger_source (
  input  wire  pclk,
  output logic trig_two,
  output logic trig_three
);
  initial trig_two = 1'b0;
  initial trig_three = 1'b0;
  // Gap 1 is the fastest legal edge rate
  task pulse(input logic sel, input int n, input int gap);
    repeat (n)
    begin
      if (sel) trig_three <= 1'b1; else trig_two <= 1'b1;
      @(posedge pclk);
      if (sel) trig_three <= 1'b0; else trig_two <= 1'b0;
      repeat (gap) @(posedge pclk);
    end
  endtask
  task level(input logic v);
    trig_two <= v;
  endtask
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam logic [11:0] a_ctl = 12'h000, a_mst = 12'h004;
  localparam logic [11:0] a_slv = 12'h008, a_ien = 12'h00C;
  localparam logic [11:0] a_sts = 12'h010, a_gen = 12'h014;
  localparam logic [11:0] a_cnt = 12'h018, a_div = 12'h01C;
  localparam logic [11:0] a_rld = 12'h020;
  logic        pclk, presetn, psel, penable, pwrite, errv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        pready, pslverr, trig_two, trig_three;
  logic        trigger_out, timer_irq;
  logic [7:0]  rst_tab [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                               8'h00, 8'h00, 8'h00, 8'hFF};
  int          err_count = 0, n_checks = 0, trig_cnt = 0, t0, i;

  basic_timer #(.ADDR_W(12)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .internal_trigger_two(trig_two), .internal_trigger_three(trig_three),
    .trigger_out(trigger_out), .timer_irq(timer_irq));
  trigger_source i_src (
    .pclk(pclk), .trig_two(trig_two), .trig_three(trig_three));

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) if (trigger_out === 1'b1) trig_cnt <= trig_cnt + 1;

  // ======================================
  // Bus tasks; one idle edge after each transfer
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task chk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    cmp(rdv, {24'h0, e});
  endtask
  task idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #40000;
    err_count++;
    summarize();
  end

  // ======================================
  // Main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 9; i++)
      chk(12'(i * 4), rst_tab[i]);
    wr(a_ien, 8'hFF);
    chk(a_ien, 8'h41);
    wr(a_ien, 8'h00);
    wr(a_div, 8'hFF);
    chk(a_div, 8'h07);
    wr(a_div, 8'h00);
    apb(1'b0, 12'h024, 8'h00);
    cmp({31'h0, errv}, 32'h1);
    apb(1'b0, 12'h002, 8'h00);
    cmp({31'h0, errv}, 32'h1);
    wr(a_cnt, 8'h20);
    t0 = trig_cnt;
    wr(a_gen, 8'h01);
    idle(3);
    cmp(trig_cnt - t0, 1);
    chk(a_cnt, 8'h00);
    chk(a_sts, 8'h01);
    chk(a_gen, 8'h00);
    wr(a_sts, 8'h00);
    wr(a_ctl, 8'h04);
    wr(a_gen, 8'h01);
    chk(a_sts, 8'h00);
    wr(a_ctl, 8'h02);
    wr(a_cnt, 8'h20);
    wr(a_gen, 8'h01);
    chk(a_cnt, 8'h00);
    chk(a_sts, 8'h00);
    wr(a_ctl, 8'h00);
    wr(a_ien, 8'h40);
    wr(a_gen, 8'h40);
    idle(2);
    chk(a_sts, 8'h40);
    cmp({31'h0, timer_irq}, 32'h1);
    wr(a_ien, 8'h00);
    idle(2);
    cmp({31'h0, timer_irq}, 32'h0);
    wr(a_sts, 8'h00);
    chk(a_sts, 8'h00);
    wr(a_mst, 8'h20);
    wr(a_rld, 8'h03);
    wr(a_ien, 8'h01);
    t0 = trig_cnt;
    wr(a_ctl, 8'h09);
    idle(30);
    chk(a_ctl, 8'h08);
    chk(a_sts, 8'h01);
    chk(a_cnt, 8'h00);
    cmp({31'h0, timer_irq}, 32'h1);
    cmp(trig_cnt - t0, 1);
    wr(a_ctl, 8'h80);
    wr(a_rld, 8'h01);
    wr(a_cnt, 8'h02);
    wr(a_ctl, 8'h89);
    idle(10);
    chk(a_ctl, 8'h88);
    wr(a_cnt, 8'h02);
    wr(a_ctl, 8'h89);
    idle(10);
    chk(a_ctl, 8'h89);
    wr(a_mst, 8'h10);
    wr(a_ctl, 8'h01);
    idle(3);
    cmp({31'h0, trigger_out}, 32'h1);
    wr(a_ctl, 8'h00);
    idle(3);
    cmp({31'h0, trigger_out}, 32'h0);
    wr(a_ien, 8'h00);
    wr(a_sts, 8'h00);
    wr(a_rld, 8'hFF);
    wr(a_slv, 8'h20);
    wr(a_slv, 8'h27);
    wr(a_cnt, 8'h00);
    wr(a_ctl, 8'h01);
    i_src.pulse(1'b0, 5, 1);
    idle(4);
    chk(a_cnt, 8'h05);
    chk(a_sts, 8'h40);
    i_src.pulse(1'b1, 3, 2);
    idle(4);
    chk(a_cnt, 8'h05);
    wr(a_div, 8'h01);
    i_src.pulse(1'b0, 4, 3);
    idle(4);
    chk(a_cnt, 8'h09);
    wr(a_gen, 8'h01);
    i_src.pulse(1'b0, 6, 1);
    idle(4);
    chk(a_cnt, 8'h03);
    wr(a_div, 8'h00);
    wr(a_gen, 8'h01);
    wr(a_slv, 8'h25);
    wr(a_cnt, 8'h00);
    idle(10);
    chk(a_cnt, 8'h00);
    i_src.level(1'b1);
    idle(10);
    i_src.level(1'b0);
    idle(4);
    chk(a_cnt, 8'h0A);
    wr(a_ctl, 8'h00);
    wr(a_slv, 8'hA5);
    i_src.level(1'b1);
    idle(2);
    cmp({31'h0, trigger_out}, 32'h0);
    idle(1);
    cmp({31'h0, trigger_out}, 32'h1);
    i_src.level(1'b0);
    idle(3);
    wr(a_slv, 8'h20);
    wr(a_slv, 8'h30);
    wr(a_slv, 8'h34);
    wr(a_sts, 8'h00);
    wr(a_cnt, 8'h50);
    i_src.pulse(1'b1, 1, 1);
    idle(4);
    chk(a_cnt, 8'h00);
    chk(a_sts, 8'h41);
    wr(a_slv, 8'h30);
    wr(a_slv, 8'h36);
    i_src.pulse(1'b1, 1, 1);
    idle(4);
    chk(a_ctl, 8'h01);
    summarize();
  end
endmodule
